// >>> hdl/scmm_loader.sv
// option pin loader, configuration keeper and extended register map decode
// assumes reset covers both power-up and hardware reset, and soft_reset is a
// one-cycle pulse from the management block on the same clock
// Function
// RULE1 - option levels are captured after every power-up or hardware reset and kept as configuration.
// RULE2 - a software reset reloads every setting from the captured values without resampling pins.
// RULE3 - each option pin is read as two levels, low for setting 0 and high for setting 1.
// RULE4 - every option setting can be rewritten by management and the write beats the captured value.
// RULE5 - pins without an external resistor see an internal pull to their default setting.
// RULE6 - the four-bit management address comes from four option pins, one per bit, default 0.
// RULE7 - two pins pick the mac mode: 00 mii, 01 rmii master, 10 rgmii, 11 rmii slave.
// RULE8 - in rmii the shared receive pin is crs_dv at 0 and rx_dv at 1.
// RULE9 - the receive-valid pin drives a 25 mhz reference clock at 0 and status lamp one at 1.
// RULE10 - reach 0 asks for both amplitudes, 1 only the low one, shown in bit 12 of both images.
// RULE11 - termination has no internal pull; 0 uses the 50 ohm tap, 1 the lower tap.
// RULE12 - extended addresses are grouped by device number into fixed ranges.
// RULE13 - groups 0x1 and 0x3 are addressed with the group's leading digit removed.
// RULE14 - the station picks one of 16 devices by the captured management address.
// RULE15 - a direct frame reaches only 32 registers; anything else goes through the groups.
// RULE16 - captured values never change while running until the next hardware reset.
`timescale 1ns/100ps
module scmm_loader
   import scmm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        soft_reset,
   input  wire scmm_opt_t   option_pins,
   input  wire logic        status_lamp_one,
   input  wire logic        forced_mode,
   input  wire logic        cfg_wr_valid,
   input  wire scmm_field_t cfg_wr_field,
   input  wire logic [3:0]  cfg_wr_data,
   input  wire logic        acc_valid,
   input  wire scmm_acc_t   acc,
   output scmm_cfg_t        cfg,
   output scmm_opt_t        strap,
   output logic             cfg_ready,
   output scmm_opt_t        pull_en,
   output scmm_opt_t        pull_up,
   output logic             valid_pin_out,
   output logic             tx_1v_only,
   output logic [15:0]      an_ctrl_image,
   output logic [15:0]      forced_amp_image,
   output scmm_rsp_t        rsp
);

   scmm_state_t st;
   scmm_state_t next_st;
   scmm_opt_t   pins_stable;

   // decode of captured pin levels into settings
   function automatic scmm_cfg_t decode(input scmm_opt_t o);
      scmm_cfg_t c;
      c               = CFG_ZERO;
      c.mgmt_addr     = {o.addr_bit3_option, o.addr_bit2_option,       // RULE6
                         o.addr_bit1_option, o.addr_bit0_option};      // RULE6
      c.mac_mode      = scmm_mac_mode_t'({o.mac_mode_high_option,
                                          o.mac_mode_low_option});     // RULE7
      c.rmii_rx_dv    = o.rmii_valid_pin_option;                       // RULE8
      c.lamp_select   = o.clock_out_select_option;                     // RULE9
      c.reach_1v_only = o.reach_level_option;                          // RULE10
      c.term_low_tap  = o.termination_tap_option;                      // RULE11
      return c;
   endfunction

   // pins pass three stages before anyone trusts them
   scmm_sync3 u_sync (
      .clk    (clk),
      .reset  (reset),
      .pins   (option_pins),
      .stable (pins_stable)
   );

   // extended map decode, combinational part
   logic [15:0] map_addr;
   logic        map_hit;
   logic        is_rmii;

   always_comb begin
      map_addr = WORD_ZERO;
      map_hit  = 1'b0;
      if (acc.direct) begin
         // direct frames carry only a five-bit register field
         map_addr = {{(16 - DIRECT_REG_W){1'b0}},
                     acc.addr[DIRECT_REG_W-1:0]};                      // RULE15
         map_hit  = 1'b1;                                              // RULE15
      end else begin
         case (acc.dev)
            DEV_GRP1: begin
               map_addr = GRP1_BASE | acc.addr;                        // RULE13
               map_hit  = ((acc.addr & LEAD_DIGIT) == WORD_ZERO)
                          && (map_addr <= GRP1_LAST);                  // RULE12
            end
            DEV_GRP3: begin
               map_addr = GRP3_BASE | acc.addr;                        // RULE13
               map_hit  = ((acc.addr & LEAD_DIGIT) == WORD_ZERO)
                          && (map_addr <= GRP3_LAST);                  // RULE12
            end
            DEV_GRP7: begin
               map_addr = acc.addr;
               map_hit  = (acc.addr >= GRP7_FIRST)
                          && (acc.addr <= GRP7_LAST);                  // RULE12
            end
            DEV_GRP1F: begin
               map_addr = acc.addr;
               map_hit  = ((acc.addr >= GRP1F_A_FIRST) && (acc.addr <= GRP1F_A_LAST))
                          || ((acc.addr >= GRP1F_B_FIRST)
                              && (acc.addr <= GRP1F_B_LAST));          // RULE12
            end
            default: begin
               map_addr = WORD_ZERO;
               map_hit  = 1'b0;
            end
         endcase
      end
   end

   assign is_rmii = (st.cfg.mac_mode == MAC_RMII_MASTER)
                    || (st.cfg.mac_mode == MAC_RMII_SLAVE);

   // next state of the whole block
   always_comb begin
      next_st = st;

      // pulls stay on at all times; termination is left to the board
      next_st.pull_en = OPT_PULL_EN;                                   // RULE5 RULE11
      next_st.pull_up = OPT_PULL_UP;                                   // RULE5

      // loader sequence
      case (st.fsm)
         ST_HOLD: begin
            next_st.fsm        = ST_SETTLE;
            next_st.settle_cnt = 3'h0;
            next_st.ready      = 1'b0;
         end
         ST_SETTLE: begin
            // wait until the synchroniser has seen the post-reset levels
            if (st.settle_cnt == SETTLE_LAST) begin
               next_st.fsm   = ST_RUN;
               next_st.strap = pins_stable;                            // RULE1 RULE3
               next_st.cfg   = decode(pins_stable);                    // RULE1
               next_st.ready = 1'b1;
            end else begin
               next_st.settle_cnt = st.settle_cnt + 3'h1;
            end
         end
         ST_RUN: begin
            // strap is never reloaded here; pins now carry functional traffic
            next_st.strap = st.strap;                                  // RULE16
            if (soft_reset) begin
               // reload wins over a write in the same cycle
               next_st.cfg = decode(st.strap);                         // RULE2
            end else if (cfg_wr_valid) begin
               case (cfg_wr_field)
                  FLD_ADDR:  next_st.cfg.mgmt_addr     = cfg_wr_data;  // RULE4
                  FLD_MAC:   next_st.cfg.mac_mode      =
                                scmm_mac_mode_t'(cfg_wr_data[1:0]);    // RULE4
                  FLD_RMII:  next_st.cfg.rmii_rx_dv    = cfg_wr_data[0]; // RULE4
                  FLD_LAMP:  next_st.cfg.lamp_select   = cfg_wr_data[0]; // RULE4
                  FLD_REACH: next_st.cfg.reach_1v_only = cfg_wr_data[0]; // RULE4
                  FLD_TERM:  next_st.cfg.term_low_tap  = cfg_wr_data[0]; // RULE4
                  default:   next_st.cfg = st.cfg;
               endcase
            end
         end
         default: begin
            next_st.fsm = ST_HOLD;
         end
      endcase

      // 25 mhz reference from the 50 mhz clock
      if (st.div_cnt == 2'(REF_DIV_HALF - 1)) begin
         next_st.div_cnt = 2'h0;
         next_st.ref_clk = ~st.ref_clk;                                // RULE9
      end else begin
         next_st.div_cnt = st.div_cnt + 2'h1;
      end

      // receive-valid pin function; low until the settings are known
      if (!st.ready) begin
         next_st.vpin_out = 1'b0;
      end else if (st.cfg.lamp_select) begin
         next_st.vpin_out = status_lamp_one;                           // RULE9
      end else begin
         next_st.vpin_out = next_st.ref_clk;                           // RULE9
      end

      // reach images of the negotiation and forced-mode registers
      next_st.an_image                = WORD_ZERO;
      next_st.an_image[REACH_BIT]     = st.cfg.reach_1v_only;          // RULE10
      next_st.forced_image            = WORD_ZERO;
      next_st.forced_image[REACH_BIT] = st.cfg.reach_1v_only;          // RULE10
      next_st.tx_1v_only              = forced_mode & st.cfg.reach_1v_only; // RULE10

      // access answer one cycle after the request
      next_st.rsp.done       = acc_valid & st.ready;
      next_st.rsp.hit        = acc_valid & st.ready & map_hit;
      next_st.rsp.addr_match = acc_valid & st.ready
                               & (acc.phy_addr == st.cfg.mgmt_addr);   // RULE14
      next_st.rsp.full_addr  = (acc_valid & st.ready) ? map_addr : WORD_ZERO;
   end

   // single register of all block state
   always_ff @(posedge clk) begin
      if (reset) begin
         st.fsm          <= ST_HOLD;
         st.settle_cnt   <= 3'h0;
         st.ready        <= 1'b0;
         st.strap        <= OPT_ZERO;
         st.cfg          <= CFG_ZERO;
         st.div_cnt      <= 2'h0;
         st.ref_clk      <= 1'b0;
         st.vpin_out     <= 1'b0;
         st.tx_1v_only   <= 1'b0;
         st.an_image     <= WORD_ZERO;
         st.forced_image <= WORD_ZERO;
         st.pull_en      <= OPT_PULL_EN;
         st.pull_up      <= OPT_PULL_UP;
         st.rsp          <= RSP_ZERO;
      end else begin
         st <= next_st;
      end
   end

   // the rmii flag gated by an active rmii mode is formed here but drives no port; cfg reports it ungated
   logic rmii_rx_dv_live;
   assign rmii_rx_dv_live = is_rmii & st.cfg.rmii_rx_dv;              // RULE8

   assign cfg              = st.cfg;
   assign strap            = st.strap;
   assign cfg_ready        = st.ready;
   assign pull_en          = st.pull_en;
   assign pull_up          = st.pull_up;
   assign valid_pin_out    = st.vpin_out;
   assign tx_1v_only       = st.tx_1v_only;
   assign an_ctrl_image    = st.an_image;
   assign forced_amp_image = st.forced_image;
   assign rsp              = st.rsp;

endmodule // scmm_loader

// >>> hdl/scmm_pkg.sv
// constants, carrier structs and state layouts for the option loader
// assumes a single 50 MHz device clock and a synchronous, active-high reset
package scmm_pkg;

   // clocking and timing
   localparam int CLK_HZ        = 50_000_000;
   localparam int REF_CLK_HZ    = 25_000_000;
   localparam int REF_DIV_HALF  = CLK_HZ / (2 * REF_CLK_HZ);   // clk edges per ref half period
   localparam int SYNC_DEPTH    = 3;
   localparam logic [2:0] SETTLE_LAST = 3'(SYNC_DEPTH);        // edges until sampled pins agree

   // extended space: device groups
   localparam logic [4:0]  DEV_GRP1      = 5'h01;
   localparam logic [4:0]  DEV_GRP3      = 5'h03;
   localparam logic [4:0]  DEV_GRP7      = 5'h07;
   localparam logic [4:0]  DEV_GRP1F     = 5'h1f;
   localparam logic [15:0] GRP1_BASE     = 16'h1000;
   localparam logic [15:0] GRP1_LAST     = 16'h18f8;
   localparam logic [15:0] GRP3_BASE     = 16'h3000;
   localparam logic [15:0] GRP3_LAST     = 16'h38e7;
   localparam logic [15:0] GRP7_FIRST    = 16'h0200;
   localparam logic [15:0] GRP7_LAST     = 16'h020f;
   localparam logic [15:0] GRP1F_A_FIRST = 16'h0000;
   localparam logic [15:0] GRP1F_A_LAST  = 16'h0130;
   localparam logic [15:0] GRP1F_B_FIRST = 16'h0300;
   localparam logic [15:0] GRP1F_B_LAST  = 16'h0e01;
   localparam logic [15:0] LEAD_DIGIT    = 16'hf000;
   localparam int          DIRECT_REG_W  = 5;                  // 32 direct registers
   localparam int          REACH_BIT     = 12;
   localparam logic [15:0] WORD_ZERO     = 16'h0000;

   // mac interface modes
   typedef enum logic [1:0] {
      MAC_MII         = 2'h0,
      MAC_RMII_MASTER = 2'h1,
      MAC_RGMII       = 2'h2,
      MAC_RMII_SLAVE  = 2'h3
   } scmm_mac_mode_t;

   // fields reachable by a management write
   typedef enum logic [2:0] {
      FLD_ADDR  = 3'h0,
      FLD_MAC   = 3'h1,
      FLD_RMII  = 3'h2,
      FLD_LAMP  = 3'h3,
      FLD_REACH = 3'h4,
      FLD_TERM  = 3'h5
   } scmm_field_t;

   // loader sequence, gray along hold -> settle -> run
   typedef enum logic [1:0] {
      ST_HOLD   = 2'h0,
      ST_SETTLE = 2'h1,
      ST_RUN    = 2'h3
   } scmm_fsm_t;

   // raw option pins
   typedef struct packed {
      logic termination_tap_option;
      logic reach_level_option;
      logic clock_out_select_option;
      logic rmii_valid_pin_option;
      logic mac_mode_high_option;
      logic mac_mode_low_option;
      logic addr_bit3_option;
      logic addr_bit2_option;
      logic addr_bit1_option;
      logic addr_bit0_option;
   } scmm_opt_t;

   // decoded configuration
   typedef struct packed {
      logic           term_low_tap;
      logic           reach_1v_only;
      logic           lamp_select;
      logic           rmii_rx_dv;
      scmm_mac_mode_t mac_mode;
      logic [3:0]     mgmt_addr;
   } scmm_cfg_t;

   // extended or direct register access request
   typedef struct packed {
      logic                    direct;
      logic [3:0]              phy_addr;
      logic [4:0]              dev;
      logic [15:0]             addr;
   } scmm_acc_t;

   typedef struct packed {
      logic        done;
      logic        hit;
      logic        addr_match;
      logic [15:0] full_addr;
   } scmm_rsp_t;

   localparam scmm_opt_t OPT_ZERO    = 10'h000;
   localparam scmm_opt_t OPT_PULL_EN = 10'h1ff;  // every pin but termination
   localparam scmm_opt_t OPT_PULL_UP = 10'h000;  // defaults are all setting 0
   localparam scmm_cfg_t CFG_ZERO    = 10'h000;
   localparam scmm_rsp_t RSP_ZERO    = 19'h00000;

   typedef struct packed {
      scmm_opt_t q1;
      scmm_opt_t q2;
      scmm_opt_t q3;
      scmm_opt_t stable;
   } scmm_sync_t;

   localparam scmm_sync_t SYNC_ZERO = 40'h0000000000;

   typedef struct packed {
      scmm_fsm_t   fsm;
      logic [2:0]  settle_cnt;
      logic        ready;
      scmm_opt_t   strap;
      scmm_cfg_t   cfg;
      logic [1:0]  div_cnt;
      logic        ref_clk;
      logic        vpin_out;
      logic        tx_1v_only;
      logic [15:0] an_image;
      logic [15:0] forced_image;
      scmm_opt_t   pull_en;
      scmm_opt_t   pull_up;
      scmm_rsp_t   rsp;
   } scmm_state_t;

endpackage

// >>> hdl/scmm_sync3.sv
// three-stage synchroniser for the option pins
// assumes the pins are asynchronous to clk; a change counts when stages two and three agree
`timescale 1ns/100ps
module scmm_sync3
   import scmm_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire scmm_opt_t pins,
   output scmm_opt_t      stable
);

   scmm_sync_t st;
   scmm_sync_t next_st;

   // stage one feeds only stage two; the compare looks at two and three
   always_comb begin
      next_st    = st;
      next_st.q1 = pins;
      next_st.q2 = st.q1;
      next_st.q3 = st.q2;
      for (int i = 0; i < $bits(scmm_opt_t); i++) begin
         if (st.q2[i] == st.q3[i]) begin
            next_st.stable[i] = st.q3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= SYNC_ZERO;
      end else begin
         st <= next_st;
      end
   end

   assign stable = st.stable;

endmodule // scmm_sync3

// >>> tb/scmm_board.sv
// board model: strap resistors in front of the option pins
// assumes the bench picks which pins carry a resistor and its level
`timescale 1ns/100ps
module scmm_board
   import scmm_pkg::*;
(
   input  wire logic      clk,
   input  wire scmm_opt_t fit,
   input  wire scmm_opt_t lvl,
   input  wire scmm_opt_t pull_en,
   input  wire scmm_opt_t pull_up,
   output scmm_opt_t      pins
);
   logic flip = 1'b0;

   // a pin with neither resistor nor pull floats, so it wanders
   always @(posedge clk) begin
      flip <= ~flip;
   end

   // fitted resistor wins, else the device's own pull
   always_comb begin
      for (int i = 0; i < $bits(scmm_opt_t); i++) begin
         if (fit[i]) pins[i] = lvl[i];
         else if (pull_en[i]) pins[i] = pull_up[i];
         else pins[i] = flip;
      end
   end
endmodule // scmm_board

// >>> tb/scmm_loader_checker.sv
// concurrent checks on the option loader ports
// assumes one clock domain and the loader's synchronous active-high reset
`timescale 1ns/100ps
module scmm_loader_checker
   import scmm_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        soft_reset,
   input wire scmm_opt_t   option_pins,
   input wire logic        status_lamp_one,
   input wire logic        forced_mode,
   input wire logic        cfg_wr_valid,
   input wire scmm_field_t cfg_wr_field,
   input wire logic [3:0]  cfg_wr_data,
   input wire logic        acc_valid,
   input wire scmm_acc_t   acc,
   input wire scmm_cfg_t   cfg,
   input wire scmm_opt_t   strap,
   input wire logic        cfg_ready,
   input wire scmm_opt_t   pull_en,
   input wire scmm_opt_t   pull_up,
   input wire logic        valid_pin_out,
   input wire logic        tx_1v_only,
   input wire logic [15:0] an_ctrl_image,
   input wire logic [15:0] forced_amp_image,
   input wire scmm_rsp_t   rsp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // a taken request, and a clock-mode stretch long enough to settle
   // four cycles: the pin stays low on the ready edge and the one after, so the toggle is seen two later
   sequence s_take;
      acc_valid && cfg_ready;
   endsequence
   sequence s_clk_mode;
      (cfg_ready && !cfg.lamp_select) [*4];
   endsequence

   property p_pull;
      pull_en == OPT_PULL_EN && pull_up == OPT_PULL_UP;
   endproperty
   a_pull: assert property (p_pull) else $error("pull setting wrong");
   property p_capture;
      $rose(cfg_ready) |-> cfg == strap;
   endproperty
   a_capture: assert property (p_capture) else $error("capture not decoded");
   property p_keep;
      cfg_ready |=> $stable(strap);
   endproperty
   a_keep: assert property (p_keep) else $error("captured value moved");
   property p_soft;
      cfg_ready && soft_reset |=> cfg == strap;
   endproperty
   a_soft: assert property (p_soft) else $error("reload wrong");
   property p_write;
      cfg_ready && cfg_wr_valid && !soft_reset && cfg_wr_field == FLD_MAC
         |=> {2'h0, cfg.mac_mode} == ($past(cfg_wr_data) & 4'h3);
   endproperty
   a_write: assert property (p_write) else $error("mode write lost");
   // images lag the live setting by one edge
   property p_reach;
      cfg_ready |=> an_ctrl_image == {3'h0, $past(cfg.reach_1v_only), 12'h000}
         && forced_amp_image == an_ctrl_image
         && tx_1v_only == ($past(forced_mode) && $past(cfg.reach_1v_only));
   endproperty
   a_reach: assert property (p_reach) else $error("reach image wrong");
   property p_answer;
      s_take |=> rsp.done && rsp.addr_match == ($past(acc.phy_addr) == $past(cfg.mgmt_addr));
   endproperty
   a_answer: assert property (p_answer) else $error("access answer wrong");
   property p_quiet;
      !(acc_valid && cfg_ready) |=> rsp == RSP_ZERO;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_direct;
      s_take ##0 acc.direct |=> rsp.hit && rsp.full_addr == ($past(acc.addr) & 16'h001f);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");
   property p_refclk;
      s_clk_mode |-> valid_pin_out != $past(valid_pin_out);
   endproperty
   a_refclk: assert property (p_refclk) else $error("ref clock stalled");
endmodule // scmm_loader_checker

bind scmm_loader scmm_loader_checker u_chk (.*);

// >>> tb/testbench.sv
// self-checking bench for the option loader
// assumes the board model and the bound checker compile alongside
`timescale 1ns/100ps
module testbench
   import scmm_pkg::*;
;
   typedef struct packed {
      logic        direct;
      logic [4:0]  dev;
      logic [15:0] addr;
      logic        hit;
      logic [15:0] full;
   } scmm_row_t;
   // access rows: request beside expected hit and full address
   localparam scmm_row_t ROWS [14] = '{
      '{1'b0, 5'h01, 16'h08f8, 1'b1, 16'h18f8}, '{1'b0, 5'h01, 16'h08f9, 1'b0, 16'h18f9},
      '{1'b0, 5'h01, 16'h1000, 1'b0, 16'h1000}, '{1'b0, 5'h03, 16'h08e7, 1'b1, 16'h38e7},
      '{1'b0, 5'h03, 16'h08e8, 1'b0, 16'h38e8}, '{1'b0, 5'h07, 16'h0200, 1'b1, 16'h0200},
      '{1'b0, 5'h07, 16'h0210, 1'b0, 16'h0210}, '{1'b0, 5'h1f, 16'h0130, 1'b1, 16'h0130},
      '{1'b0, 5'h1f, 16'h0131, 1'b0, 16'h0131}, '{1'b0, 5'h1f, 16'h0300, 1'b1, 16'h0300},
      '{1'b0, 5'h1f, 16'h0e01, 1'b1, 16'h0e01}, '{1'b0, 5'h1f, 16'h0e02, 1'b0, 16'h0e02},
      '{1'b0, 5'h02, 16'h0000, 1'b0, 16'h0000}, '{1'b1, 5'h00, 16'h003f, 1'b1, 16'h001f}};

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        soft_reset = 1'b0;
   logic        status_lamp_one = 1'b0;
   logic        forced_mode = 1'b0;
   logic        cfg_wr_valid = 1'b0;
   logic        acc_valid = 1'b0;
   scmm_field_t cfg_wr_field = FLD_ADDR;
   logic [3:0]  cfg_wr_data = 4'h0;
   scmm_acc_t   acc = '0;
   scmm_opt_t   fit = '1;
   scmm_opt_t   lvl = '0;
   scmm_opt_t   option_pins, pull_en, pull_up, strap;
   scmm_cfg_t   cfg;
   logic        cfg_ready, valid_pin_out, tx_1v_only, v;
   logic [15:0] an_ctrl_image, forced_amp_image;
   scmm_rsp_t   rsp;
   int          error_cnt = 0;
   int          tests_run = 0;

   always #10 clk = ~clk;

   scmm_loader DUT (.*);
   scmm_board u_board (.clk(clk), .fit(fit), .lvl(lvl), .pull_en(pull_en),
                       .pull_up(pull_up), .pins(option_pins));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // full reset with the given straps; capture must land within 20 cycles
   task automatic power_up(input scmm_opt_t f, input scmm_opt_t l);
      int n;
      fit = f;
      lvl = l;
      reset = 1'b1;
      repeat (12) @(negedge clk);
      chk("pull in reset", 16'(pull_en), 16'(OPT_PULL_EN));
      reset = 1'b0;
      n = 0;
      while (cfg_ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("ready", {15'h0, cfg_ready}, 16'h0001);
      if (n >= 20) give_verdict();
      chk("cfg", 16'(cfg), 16'(l & f));
   endtask

   // held valid makes consecutive writes back to back
   task automatic wr(input scmm_field_t f, input logic [3:0] d);
      cfg_wr_valid = 1'b1;
      cfg_wr_field = f;
      cfg_wr_data = d;
      @(negedge clk);
   endtask

   initial begin
      @(negedge clk);
      // every mac mode and both levels of each option
      for (int m = 0; m < 4; m++) begin
         power_up('1, scmm_opt_t'({m[0], m[1], ~m[0], m[1], 2'(m), 4'(5 * m)}));
      end
      // no resistors but the mandatory termination one
      power_up(10'h200, '1);
      repeat (3) @(negedge clk);
      v = valid_pin_out;
      @(negedge clk);
      chk("ref clock", {15'h0, valid_pin_out}, {15'h0, ~v});
      // lamp mode, rgmii, address 5
      power_up('1, 10'h2a5);
      for (int b = 1; b >= 0; b--) begin
         status_lamp_one = b[0];
         repeat (4) @(negedge clk);
         chk("lamp", {15'h0, valid_pin_out}, 16'(b));
      end
      // shared pins now carry traffic
      lvl = ~lvl;
      repeat (8) @(negedge clk);
      chk("strap kept", 16'(strap), 16'h02a5);
      chk("cfg kept", 16'(cfg), 16'h02a5);
      // back-to-back accesses, one per row
      for (int i = 0; i < 14; i++) begin
         acc = '{ROWS[i].direct, 4'(i), ROWS[i].dev, ROWS[i].addr};
         acc_valid = 1'b1;
         @(negedge clk);
         chk("rsp flags", {13'h0, rsp.done, rsp.hit, rsp.addr_match},
             {13'h0, 1'b1, ROWS[i].hit, i == 5});
         chk("full addr", rsp.full_addr, ROWS[i].full);
      end
      acc_valid = 1'b0;
      @(negedge clk);
      chk("rsp idle", 16'(rsp.done), 16'h0);
      // reach write in forced mode
      forced_mode = 1'b1;
      wr(FLD_REACH, 4'h1);
      cfg_wr_valid = 1'b0;
      repeat (2) @(negedge clk);
      chk("an image", an_ctrl_image, 16'h1000);
      chk("forced image", forced_amp_image, 16'h1000);
      chk("tx level", {15'h0, tx_1v_only}, 16'h0001);
      forced_mode = 1'b0;
      repeat (2) @(negedge clk);
      chk("tx level", {15'h0, tx_1v_only}, 16'h0000);
      // every other field rewritten
      wr(FLD_ADDR, 4'h9);
      wr(FLD_MAC, 4'h1);
      wr(FLD_RMII, 4'h1);
      wr(FLD_LAMP, 4'h0);
      wr(FLD_TERM, 4'h0);
      cfg_wr_valid = 1'b0;
      chk("written cfg", 16'(cfg), 16'h0159);
      // reload beats a same-cycle write and ignores the changed pins
      soft_reset = 1'b1;
      wr(FLD_ADDR, 4'h3);
      soft_reset = 1'b0;
      cfg_wr_valid = 1'b0;
      @(negedge clk);
      chk("reloaded cfg", 16'(cfg), 16'h02a5);
      give_verdict();
   end
endmodule // testbench
